/* logic/lps_host.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module lps_host import lps_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	lps_link_if.host link,
	input wire logic [7:0] sw_addr_in,
	input wire logic [7:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [7:0] sw_rdata_out
);
	typedef struct packed {
		lps_hstate_t fsm;
		logic [7:0] tgt;
		logic [7:0] wdata;
		logic wr;
		logic [7:0] rdata;
		logic [15:0] word;
		logic busy;
		logic [7:0] l_addr;
		logic [7:0] l_wdata;
		logic l_wr;
		logic l_rd;
		logic [7:0] sw_rdata;
	} lps_hst_t;
	lps_hst_t st_q, st_d;

	// ----------------------------------------
	// command sequencing
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.l_wr = 1'b0;
		st_d.l_rd = 1'b0;
		st_d.sw_rdata = 8'h00;
		if (sw_wr_in) begin
			unique case (sw_addr_in)
				LPS_HC_ADDR: st_d.tgt = sw_wdata_in;
				LPS_HC_WDATA: begin
					// writes aimed at the status register are sent as all zero
					st_d.wdata = (st_q.tgt == LPS_ADDR_STAT) ? 8'h00 : sw_wdata_in;
				end
				LPS_HC_CMD: begin
					if (!st_q.busy) begin
						st_d.busy = 1'b1;
						st_d.l_addr = st_q.tgt;
						st_d.l_wdata = st_q.wdata;
						st_d.l_wr = sw_wdata_in[LPS_HC_CMD_WR];
						st_d.l_rd = sw_wdata_in[LPS_HC_CMD_RD] | sw_wdata_in[LPS_HC_CMD_WORD];
						// word read: low byte then high byte back to back
						st_d.fsm = sw_wdata_in[LPS_HC_CMD_WORD] ? LPS_HS_LO : LPS_HS_IDLE;
						if (!sw_wdata_in[LPS_HC_CMD_WORD] && !sw_wdata_in[LPS_HC_CMD_RD])
							st_d.busy = 1'b0;
					end
				end
				default: ;
			endcase
		end
		unique case (st_q.fsm)
			LPS_HS_IDLE: begin
				if (st_q.busy && !st_q.l_rd && !st_q.l_wr) begin
					st_d.rdata = link.rdata;
					st_d.busy = 1'b0;
				end
			end
			LPS_HS_LO: begin
				st_d.l_addr = st_q.l_addr + 8'h01;
				st_d.l_rd = 1'b1;
				st_d.fsm = LPS_HS_HI;
			end
			LPS_HS_HI: begin
				st_d.word[7:0] = link.rdata;
				st_d.fsm = LPS_HS_IDLE;
			end
			default: st_d.fsm = LPS_HS_IDLE;
		endcase
		if (st_q.fsm == LPS_HS_IDLE && st_q.busy && !st_q.l_rd && !st_q.l_wr) begin
			st_d.word[15:8] = link.rdata;
		end
		if (sw_rd_in) begin
			unique case (sw_addr_in)
				LPS_HC_ADDR: st_d.sw_rdata = st_q.tgt;
				LPS_HC_WDATA: st_d.sw_rdata = st_q.wdata;
				LPS_HC_RDATA: st_d.sw_rdata = st_q.rdata;
				LPS_HC_STAT: st_d.sw_rdata = {7'h00, st_q.busy};
				LPS_HC_WORD: st_d.sw_rdata = st_q.word[7:0];
				default: st_d.sw_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign link.addr = st_q.l_addr;
	assign link.wdata = st_q.l_wdata;
	assign link.wr = st_q.l_wr;
	assign link.rd = st_q.l_rd;
	assign sw_rdata_out = st_q.sw_rdata;
endmodule

/* logic/lps_pkg.sv */
package lps_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] LPS_ADDR_CTRL = 8'h0F;
	localparam logic [7:0] LPS_ADDR_REV = 8'h11;
	localparam logic [7:0] LPS_ADDR_PART = 8'h12;
	localparam logic [7:0] LPS_ADDR_STAT = 8'h13;
	localparam logic [7:0] LPS_ADDR_VIS_LO = 8'h14;
	localparam logic [7:0] LPS_ADDR_VIS_HI = 8'h15;
	localparam logic [7:0] LPS_ADDR_IR_LO = 8'h16;
	localparam logic [7:0] LPS_ADDR_IR_HI = 8'h17;
	localparam logic [7:0] LPS_ADDR_PROX_LO = 8'h18;
	localparam logic [7:0] LPS_ADDR_PROX_HI = 8'h19;
	// host controller registers
	localparam logic [7:0] LPS_HC_ADDR = 8'h00;
	localparam logic [7:0] LPS_HC_WDATA = 8'h01;
	localparam logic [7:0] LPS_HC_CMD = 8'h02;
	localparam logic [7:0] LPS_HC_RDATA = 8'h03;
	localparam logic [7:0] LPS_HC_STAT = 8'h04;
	localparam logic [7:0] LPS_HC_WORD = 8'h05;
	localparam int LPS_HC_CMD_RD = 0;
	localparam int LPS_HC_CMD_WR = 1;
	localparam int LPS_HC_CMD_WORD = 2;
	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int LPS_LED_MSB = 7;
	localparam int LPS_LED_LSB = 6;
	localparam int LPS_PROX_DIODE_SELECT_MSB = 5;
	localparam int LPS_PROX_DIODE_SELECT_LSB = 4;
	localparam int LPS_PROX_AMP_GAIN_MSB = 3;
	localparam int LPS_PROX_AMP_GAIN_LSB = 2;
	localparam int LPS_LIGHT_AMP_GAIN_MSB = 1;
	localparam int LPS_LIGHT_AMP_GAIN_LSB = 0;
	localparam int LPS_ST_PROX_IRQ_FLAG = 5;
	localparam int LPS_ST_LIGHT_IRQ_FLAG = 4;
	localparam int LPS_ST_PROX_RESULT_VALID = 1;
	localparam int LPS_ST_LIGHT_RESULT_VALID = 0;
	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [7:0] LPS_CTRL_RST = 8'h00;
	localparam logic [1:0] LPS_PROX_DIODE_SELECT_CH1 = 2'h2;
	localparam logic [1:0] LPS_PROX_AMP_GAIN_1X = 2'h0;
	// arbitrary identity values
	localparam logic [7:0] LPS_REV_CODE = 8'h5A;
	localparam logic [7:0] LPS_PART_CODE = 8'hA5;
	// host access states
	typedef enum logic [1:0] {
		LPS_HS_IDLE = 2'b00,
		LPS_HS_LO = 2'b01,
		LPS_HS_HI = 2'b10
	} lps_hstate_t;
endpackage

/* logic/lps_link_if.sv */
`timescale 1ns/1ps
interface lps_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* logic/lps_dev.sv */
`timescale 1ns/1ps
// Summary of operation
// - control byte steers analog front end
// - bits 7:6 pick LED current
// - host programs diode select to 10; lps_host forwards any value
// - host keeps proximity gain at 00; lps_host forwards any value
// - bits 1:0 pick light amp gain
// - revision byte fixed, writes ignored
// - part number byte fixed, read-only
// - status read-only, writes ignored
// - bit 5 shows proximity interrupt
// - bit 4 shows light interrupt
// - bit 1 set after proximity integration
// - bit 0 set after light integration
// - host writes zero to reserved status
// - two light counts, low byte first
// - proximity count at 0x18/0x19
// - low byte read shadows high byte
// - shadow survives later conversions
// - host uses paired word reads
// - interrupt flags follow light_irq_in and prox_irq_in
module lps_dev import lps_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	lps_link_if.dev link,
	input wire logic light_done_in,
	input wire logic [15:0] vis_count_in,
	input wire logic [15:0] ir_count_in,
	input wire logic prox_done_in,
	input wire logic [15:0] prox_count_in,
	input wire logic light_irq_in,
	input wire logic prox_irq_in,
	output logic [1:0] led_drive_level_out,
	output logic [1:0] prox_diode_select_out,
	output logic [1:0] prox_amp_gain_out,
	output logic [1:0] light_amp_gain_out,
	output logic irq_out
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] vis;
		logic [15:0] ir;
		logic [15:0] prox;
		logic [2:0][7:0] shadow;
		logic light_valid;
		logic prox_valid;
		logic [7:0] rdata;
	} lps_dstate_t;
	lps_dstate_t st_q, st_d;
	logic [7:0] status;

	// ----------------------------------------
	// register access
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		status = 8'h00;
		status[LPS_ST_PROX_IRQ_FLAG] = prox_irq_in;
		status[LPS_ST_LIGHT_IRQ_FLAG] = light_irq_in;
		status[LPS_ST_PROX_RESULT_VALID] = st_q.prox_valid;
		status[LPS_ST_LIGHT_RESULT_VALID] = st_q.light_valid;
		if (light_done_in) begin
			st_d.vis = vis_count_in;
			st_d.ir = ir_count_in;
			st_d.light_valid = 1'b1;
		end
		if (prox_done_in) begin
			st_d.prox = prox_count_in;
			st_d.prox_valid = 1'b1;
		end
		// only the control byte is writable
		if (link.wr && link.addr == LPS_ADDR_CTRL) begin
			st_d.ctrl = link.wdata;
		end
		st_d.rdata = 8'h00;
		if (link.rd) begin
			unique case (link.addr)
				LPS_ADDR_CTRL: st_d.rdata = st_q.ctrl;
				LPS_ADDR_REV: st_d.rdata = LPS_REV_CODE;
				LPS_ADDR_PART: st_d.rdata = LPS_PART_CODE;
				LPS_ADDR_STAT: st_d.rdata = status;
				LPS_ADDR_VIS_LO: begin
					st_d.rdata = st_q.vis[7:0];
					st_d.shadow[0] = st_q.vis[15:8];
				end
				LPS_ADDR_IR_LO: begin
					st_d.rdata = st_q.ir[7:0];
					st_d.shadow[1] = st_q.ir[15:8];
				end
				LPS_ADDR_PROX_LO: begin
					st_d.rdata = st_q.prox[7:0];
					st_d.shadow[2] = st_q.prox[15:8];
				end
				LPS_ADDR_VIS_HI: st_d.rdata = st_q.shadow[0];
				LPS_ADDR_IR_HI: st_d.rdata = st_q.shadow[1];
				LPS_ADDR_PROX_HI: st_d.rdata = st_q.shadow[2];
				default: st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.ctrl <= LPS_CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign led_drive_level_out = st_q.ctrl[LPS_LED_MSB:LPS_LED_LSB];
	assign prox_diode_select_out = st_q.ctrl[LPS_PROX_DIODE_SELECT_MSB:LPS_PROX_DIODE_SELECT_LSB];
	assign prox_amp_gain_out = st_q.ctrl[LPS_PROX_AMP_GAIN_MSB:LPS_PROX_AMP_GAIN_LSB];
	assign light_amp_gain_out = st_q.ctrl[LPS_LIGHT_AMP_GAIN_MSB:LPS_LIGHT_AMP_GAIN_LSB];
	// level interrupt pin mirrors the two flags
	assign irq_out = light_irq_in | prox_irq_in;
	assign link.rdata = st_q.rdata;
endmodule

/* bench/lps_properties.sv */
`timescale 1ns/1ps
module lps_properties import lps_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	// ----------------------------------------
	// control byte mirror
	// ----------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr && addr == LPS_ADDR_CTRL) begin
			ctrl_d = wdata;
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= LPS_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_excl; !(wr && rd); endproperty
	property p_wr_pulse; wr |=> !wr; endproperty
	property p_rev; rd && addr == LPS_ADDR_REV |=> rdata == LPS_REV_CODE; endproperty
	property p_part; rd && addr == LPS_ADDR_PART |=> rdata == LPS_PART_CODE; endproperty
	property p_stat_rsvd; rd && addr == LPS_ADDR_STAT |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0;
	endproperty
	property p_ctrl_back; rd && addr == LPS_ADDR_CTRL |=> rdata == $past(ctrl_q); endproperty
	property p_unmapped; rd && addr == 8'h10 |=> rdata == 8'h00; endproperty
	// answer stands one cycle only, so stale data never leaks into a later read
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	a_excl: assert property (p_excl) else $error("both strobes high");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	a_rev: assert property (p_rev) else $error("revision byte wrong");
	a_part: assert property (p_part) else $error("part byte wrong");
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
	a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_idle: assert property (p_idle) else $error("read data outside answer");
	c_ctrl_wr: cover property (wr && addr == LPS_ADDR_CTRL);
	c_vis_lo: cover property (rd && addr == LPS_ADDR_VIS_LO);
	c_prox_hi: cover property (rd && addr == LPS_ADDR_PROX_HI);
endmodule

/* bench/lps_tb.sv */
`timescale 1ns/1ps
module lps_tb import lps_pkg::*;;
	logic clk_in, rst_in, l_done, p_done, l_irq, p_irq, s_wr, s_rd;
	logic [15:0] vis, ir, prox;
	logic [7:0] s_addr, s_wdata, s_rdata, v, r;
	logic [1:0] led, pdi, pga, aga;
	logic irq;
	int checks = 0;
	int err_total = 0;
	lps_link_if i_lps_link_if ();
	lps_dev i_lps_dev (.clk_in(clk_in), .rst_in(rst_in), .link(i_lps_link_if.dev),
		.light_done_in(l_done), .vis_count_in(vis), .ir_count_in(ir), .prox_done_in(p_done),
		.prox_count_in(prox), .light_irq_in(l_irq), .prox_irq_in(p_irq),
		.led_drive_level_out(led), .prox_diode_select_out(pdi), .prox_amp_gain_out(pga),
		.light_amp_gain_out(aga), .irq_out(irq));
	lps_host i_lps_host (.clk_in(clk_in), .rst_in(rst_in), .link(i_lps_link_if.host),
		.sw_addr_in(s_addr), .sw_wdata_in(s_wdata), .sw_wr_in(s_wr), .sw_rd_in(s_rd),
		.sw_rdata_out(s_rdata));
	lps_properties i_lps_properties (.clk_in(clk_in), .rst_in(rst_in),
		.addr(i_lps_link_if.addr), .wdata(i_lps_link_if.wdata), .wr(i_lps_link_if.wr),
		.rd(i_lps_link_if.rd), .rdata(i_lps_link_if.rdata));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic sw_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		s_addr <= a;
		s_wdata <= d;
		s_wr <= 1'b1;
		@(posedge clk_in);
		s_wr <= 1'b0;
	endtask
	task automatic sw_r(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		s_addr <= a;
		s_rd <= 1'b1;
		@(posedge clk_in);
		s_rd <= 1'b0;
		@(negedge clk_in);
		d = s_rdata;
	endtask
	task automatic acc(input logic [7:0] c, input logic [7:0] t, input logic [7:0] d);
		int n;
		logic [7:0] s;
		n = 0;
		sw_w(LPS_HC_ADDR, t);
		sw_w(LPS_HC_WDATA, d);
		sw_w(LPS_HC_CMD, c);
		// bounded poll of 40 reads; a stuck busy is counted as an error here
		do begin
			sw_r(LPS_HC_STAT, s);
			n++;
		end while (s[0] !== 1'b0 && n < 40);
		if (n >= 40) begin
			err_total++;
			$display("MISMATCH t=%0t host stuck busy", $time);
		end
		sw_r(LPS_HC_RDATA, r);
	endtask
	task automatic dwr(input logic [7:0] t, input logic [7:0] d);
		acc(8'h01 << LPS_HC_CMD_WR, t, d);
	endtask
	task automatic drd(input logic [7:0] t, input logic [7:0] e);
		acc(8'h01 << LPS_HC_CMD_RD, t, 8'h00);
		chk(r, e);
	endtask
	task automatic pls(input logic p);
		@(posedge clk_in);
		p_done <= p;
		l_done <= !p;
		@(posedge clk_in);
		p_done <= 1'b0;
		l_done <= 1'b0;
	endtask
	task print_verdict;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		#1000000;
		err_total++;
		print_verdict;
	end
	initial begin
		{rst_in, l_done, p_done, l_irq, p_irq, s_wr, s_rd} = 7'h40;
		{vis, ir, prox, s_addr, s_wdata} = '0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		drd(LPS_ADDR_CTRL, LPS_CTRL_RST);
		drd(LPS_ADDR_STAT, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], LPS_PROX_DIODE_SELECT_CH1, LPS_PROX_AMP_GAIN_1X, i[1:0]};
			dwr(LPS_ADDR_CTRL, v);
			chk({led, pdi, pga, aga}, v);
		end
		dwr(LPS_ADDR_CTRL, 8'hFF);
		drd(LPS_ADDR_CTRL, 8'hFF);
		dwr(LPS_ADDR_REV, 8'h00);
		drd(LPS_ADDR_REV, LPS_REV_CODE);
		drd(LPS_ADDR_PART, LPS_PART_CODE);
		drd(8'h10, 8'h00);
		@(posedge clk_in);
		p_irq <= 1'b1;
		dwr(LPS_ADDR_STAT, 8'hFF);
		sw_r(LPS_HC_WDATA, v);
		chk(v, 8'h00);
		drd(LPS_ADDR_STAT, 8'h20);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk_in);
		p_irq <= 1'b0;
		l_irq <= 1'b1;
		drd(LPS_ADDR_STAT, 8'h10);
		@(posedge clk_in);
		l_irq <= 1'b0;
		{vis, ir, prox} <= 48'h1234_5678_9ABC;
		pls(1'b0);
		drd(LPS_ADDR_STAT, 8'h01);
		pls(1'b1);
		drd(LPS_ADDR_STAT, 8'h03);
		drd(LPS_ADDR_VIS_LO, 8'h34);
		vis <= 16'hBEEF;
		pls(1'b0);
		drd(LPS_ADDR_VIS_HI, 8'h12);
		drd(LPS_ADDR_IR_LO, 8'h78);
		drd(LPS_ADDR_IR_HI, 8'h56);
		drd(LPS_ADDR_PROX_LO, 8'hBC);
		drd(LPS_ADDR_PROX_HI, 8'h9A);
		acc(8'h01 << LPS_HC_CMD_WORD, LPS_ADDR_PROX_LO, 8'h00);
		chk(r, 8'h9A);
		sw_r(LPS_HC_WORD, v);
		chk(v, 8'hBC);
		print_verdict;
	end
endmodule
